// ==== src/ueirq_top.v ====
// How it works
// - out endpoint flags reach summary only when common enable bit set
// - enable bit 6 gates back-to-back setup, control endpoint 0 only
// - enable bit 4 gates rx fifo overrun on out endpoints
// - enable bit 3 gates setup done, control endpoint 0 only
// - enable bit 1 gates endpoint disabled on out endpoints
// - enable bit 0 gates transfer done on out endpoints
// - summary bit set whenever an enabled endpoint event fires
// - out endpoint summary bits at 19:16, endpoint 0 at 16
// - in endpoint summary bits at 3:0, endpoint 0 at 0
// - global out/in flags raised only by endpoints with mask bit set
// - out endpoint mask bits at 19:16, endpoint 0 at 16
// - in endpoint mask bits at 3:0, endpoint 0 at 0
// - vbus discharge lasts 1024 times discharge field clock periods
// - vbus pulse lasts 1024 times pulse field clock periods
`timescale 1ns/1ps
`include "ueirq_regs.vh"
module ueirq_top #(
   parameter EP_COUNT   = 4,
   parameter UNIT_CYCLES = `UEIRQ_UNIT_CYCLES
) (
   // clock and reset
   input  wire        mclk,
   input  wire        resetn,
   // register port
   input  wire [11:0] reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // endpoint flag levels from the endpoint flag registers
   input  wire [EP_COUNT*7-1:0] out_ep_flags,
   input  wire [EP_COUNT-1:0]   in_ep_event,
   // session request sequencing
   output reg         vbus_pulse,
   output reg         vbus_discharge,
   // global flags and interrupt
   output reg         global_out_endpoint_flag,
   output reg         global_in_endpoint_flag,
   output reg         irq
);

   localparam ST_IDLE  = 2'd0;
   localparam ST_PULSE = 2'd1;
   localparam ST_DISCH = 2'd2;

   reg  [31:0]         out_en;
   reg  [31:0]         ep_mask;
   reg  [15:0]         vbus_discharge_field;
   reg  [11:0]         vbus_pulse_field;
   reg  [EP_COUNT-1:0] out_sum;
   reg  [EP_COUNT-1:0] in_sum;
   reg  [1:0]          state;
   reg  [9:0]          unit_cnt;
   reg  [15:0]         unit_left;
   reg  [`UEIRQ_IRQ_BITS-1:0] irq_stat;
   reg  [`UEIRQ_IRQ_BITS-1:0] irq_en;
   wire [EP_COUNT-1:0] out_hit;
   wire [EP_COUNT-1:0] ovr_hit;
   wire [EP_COUNT-1:0] out_sum_en;
   wire [EP_COUNT-1:0] in_sum_en;
   wire                unit_tick;
   wire                srp_start;
   wire                srp_done;
   wire [`UEIRQ_IRQ_BITS-1:0] irq_set;
   wire [`UEIRQ_IRQ_BITS-1:0] irq_clr;

   // common enable applied per endpoint; setup events only on control ep 0
   function endpoint_hit;
      input [6:0]  flags;
      input [31:0] en;
      input        is_ctrl;
      begin
         endpoint_hit = (flags[`UEIRQ_BIT_XFER_DONE]  & en[`UEIRQ_BIT_XFER_DONE])
                      | (flags[`UEIRQ_BIT_EP_OFF]     & en[`UEIRQ_BIT_EP_OFF])
                      | (flags[`UEIRQ_BIT_RX_OVERRUN] & en[`UEIRQ_BIT_RX_OVERRUN])
                      | (is_ctrl & flags[`UEIRQ_BIT_SETUP_DONE]
                                 & en[`UEIRQ_BIT_SETUP_DONE])
                      | (is_ctrl & flags[`UEIRQ_BIT_B2B_SETUP]
                                 & en[`UEIRQ_BIT_B2B_SETUP]);
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < EP_COUNT; g = g + 1) begin : g_ep
         assign out_hit[g] = endpoint_hit(out_ep_flags[g*7 +: 7], out_en, g == 0);
         assign ovr_hit[g] = out_ep_flags[g*7 + `UEIRQ_BIT_RX_OVERRUN]
                           & out_en[`UEIRQ_BIT_RX_OVERRUN];
      end
   endgenerate

   // summary is a registered copy of the level, so it clears itself
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         out_sum <= {EP_COUNT{1'b0}};
         in_sum  <= {EP_COUNT{1'b0}};
      end else begin
         out_sum <= out_hit;
         in_sum  <= in_ep_event;
      end
   end

   assign out_sum_en = out_sum & ep_mask[`UEIRQ_OUT_LSB +: EP_COUNT];
   assign in_sum_en  = in_sum & ep_mask[EP_COUNT-1:0];

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         global_out_endpoint_flag <= 1'b0;
         global_in_endpoint_flag  <= 1'b0;
      end else begin
         global_out_endpoint_flag <= |out_sum_en;
         global_in_endpoint_flag  <= |in_sum_en;
      end
   end

   // session request: pulse then discharge, both in 1024-cycle units
   assign unit_tick = ({22'h000000, unit_cnt} == UNIT_CYCLES - 1);
   assign srp_start = reg_wr && reg_addr == `UEIRQ_OFS_SRP_CTRL && reg_wdata[0];
   // a zero discharge skips that phase, so done is reported at the end of the pulse
   assign srp_done  = unit_tick && unit_left <= 16'h0001
                      && (state == ST_DISCH
                          || (state == ST_PULSE && vbus_discharge_field == 16'h0000));

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state          <= ST_IDLE;
         unit_cnt       <= 10'h000;
         unit_left      <= 16'h0000;
         vbus_pulse     <= 1'b0;
         vbus_discharge <= 1'b0;
      end else begin
         unit_cnt <= (state == ST_IDLE || unit_tick) ? 10'h000 : unit_cnt + 10'h001;
         case (state)
            ST_IDLE: begin
               if (srp_start && vbus_pulse_field != 12'h000) begin
                  state      <= ST_PULSE;
                  unit_left  <= {4'h0, vbus_pulse_field};
                  vbus_pulse <= 1'b1;
               end
            end
            ST_PULSE: begin
               if (unit_tick) begin
                  unit_left <= unit_left - 16'h0001;
                  if (unit_left == 16'h0001) begin
                     vbus_pulse <= 1'b0;
                     unit_left  <= vbus_discharge_field;
                     if (vbus_discharge_field == 16'h0000) begin
                        state <= ST_IDLE;
                     end else begin
                        state          <= ST_DISCH;
                        vbus_discharge <= 1'b1;
                     end
                  end
               end
            end
            ST_DISCH: begin
               if (unit_tick) begin
                  unit_left <= unit_left - 16'h0001;
                  if (unit_left == 16'h0001) begin
                     state          <= ST_IDLE;
                     vbus_discharge <= 1'b0;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // register writes; reserved bits forced to zero
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         out_en               <= `UEIRQ_RST_OUT_EN;
         ep_mask              <= `UEIRQ_RST_EP_MASK;
         vbus_discharge_field <= `UEIRQ_RST_DISCHARGE;
         vbus_pulse_field     <= `UEIRQ_RST_PULSE;
         irq_en               <= {`UEIRQ_IRQ_BITS{1'b0}};
      end else if (reg_wr) begin
         case (reg_addr)
            `UEIRQ_OFS_OUT_EN:    out_en  <= reg_wdata & `UEIRQ_OUT_EN_MASK;
            `UEIRQ_OFS_EP_MASK:   ep_mask <= reg_wdata & `UEIRQ_EP_MASK_MASK;
            `UEIRQ_OFS_DISCHARGE: vbus_discharge_field <= reg_wdata[15:0];
            `UEIRQ_OFS_PULSE:     vbus_pulse_field <= reg_wdata[11:0];
            `UEIRQ_OFS_IRQ_EN:    irq_en <= reg_wdata[`UEIRQ_IRQ_BITS-1:0];
            default: begin
            end
         endcase
      end
   end

   // sticky status; a set in the clear cycle wins
   assign irq_set = {|(ovr_hit & ~out_sum), |in_sum_en & ~global_in_endpoint_flag,
                     |out_sum_en & ~global_out_endpoint_flag, srp_done};
   assign irq_clr = (reg_wr && reg_addr == `UEIRQ_OFS_IRQ_CLR) ?
                    reg_wdata[`UEIRQ_IRQ_BITS-1:0] : {`UEIRQ_IRQ_BITS{1'b0}};

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         irq_stat <= {`UEIRQ_IRQ_BITS{1'b0}};
         irq      <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
         irq      <= |(((irq_stat & ~irq_clr) | irq_set) & irq_en);
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            `UEIRQ_OFS_OUT_EN:    reg_rdata <= out_en;
            `UEIRQ_OFS_SUMMARY:   reg_rdata <= {12'h000, out_sum, 12'h000, in_sum};
            `UEIRQ_OFS_EP_MASK:   reg_rdata <= ep_mask;
            `UEIRQ_OFS_DISCHARGE: reg_rdata <= {16'h0000, vbus_discharge_field};
            `UEIRQ_OFS_PULSE:     reg_rdata <= {20'h00000, vbus_pulse_field};
            `UEIRQ_OFS_SRP_CTRL:  reg_rdata <= {30'h0, vbus_discharge, vbus_pulse};
            `UEIRQ_OFS_IRQ_STAT:  reg_rdata <= {28'h0000000, irq_stat};
            `UEIRQ_OFS_IRQ_EN:    reg_rdata <= {28'h0000000, irq_en};
            default:              reg_rdata <= 32'h00000000;
         endcase
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule // ueirq_top

// ==== shared/ueirq_regs.vh ====
`ifndef UEIRQ_REGS_VH
`define UEIRQ_REGS_VH
`define UEIRQ_OFS_OUT_EN      12'h814
`define UEIRQ_OFS_SUMMARY     12'h818
`define UEIRQ_OFS_EP_MASK     12'h81c
`define UEIRQ_OFS_DISCHARGE   12'h828
`define UEIRQ_OFS_PULSE       12'h82c
`define UEIRQ_OFS_SRP_CTRL    12'h830
`define UEIRQ_OFS_IRQ_STAT    12'h834
`define UEIRQ_OFS_IRQ_CLR     12'h838
`define UEIRQ_OFS_IRQ_EN      12'h83c
`define UEIRQ_BIT_XFER_DONE   0
`define UEIRQ_BIT_EP_OFF      1
`define UEIRQ_BIT_SETUP_DONE  3
`define UEIRQ_BIT_RX_OVERRUN  4
`define UEIRQ_BIT_B2B_SETUP   6
`define UEIRQ_OUT_EN_MASK     32'h0000005b
`define UEIRQ_OUT_LSB         16
`define UEIRQ_EP_MASK_MASK    32'h000f000f
`define UEIRQ_RST_OUT_EN      32'h00000000
`define UEIRQ_RST_EP_MASK     32'h00000000
`define UEIRQ_RST_DISCHARGE   16'h17d7
`define UEIRQ_RST_PULSE       12'h5b8
`define UEIRQ_UNIT_CYCLES     1024
`define UEIRQ_IRQ_BITS        4
`define UEIRQ_IRQ_SRP_DONE    0
`define UEIRQ_IRQ_GLOBAL_OUT  1
`define UEIRQ_IRQ_GLOBAL_IN   2
`define UEIRQ_IRQ_OVERRUN     3
`endif

// ==== test/ueirq_monitor.sv ====
`timescale 1ns/1ps
module ueirq_monitor #(
   parameter EP_COUNT = 4
) (
   // clock and reset
   input wire                  mclk,
   input wire                  resetn,
   // register port
   input wire [11:0]           reg_addr,
   input wire [31:0]           reg_wdata,
   input wire                  reg_wr,
   input wire                  reg_rd,
   input wire [31:0]           reg_rdata,
   // endpoint events and outputs
   input wire [EP_COUNT*7-1:0] out_ep_flags,
   input wire [EP_COUNT-1:0]   in_ep_event,
   input wire                  vbus_pulse,
   input wire                  vbus_discharge,
   input wire                  global_out_endpoint_flag,
   input wire                  global_in_endpoint_flag,
   input wire                  irq
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not idle");
   chk_sum_reserved: assert property ($past(reg_rd) && $past(reg_addr) == 12'h818
      |-> (reg_rdata & 32'hfff0fff0) == 32'h0) else $error("summary reserved bits set");
   chk_out_en_reserved: assert property ($past(reg_rd) && $past(reg_addr) == 12'h814
      |-> (reg_rdata & 32'hffffffa4) == 32'h0) else $error("enable reserved bits set");
   chk_mask_reserved: assert property ($past(reg_rd) && $past(reg_addr) == 12'h81c
      |-> (reg_rdata & 32'hfff0fff0) == 32'h0) else $error("mask reserved bits set");
   chk_dis_reserved: assert property ($past(reg_rd) && $past(reg_addr) == 12'h828
      |-> reg_rdata[31:16] == 16'h0) else $error("discharge reserved bits set");
   chk_phase_excl: assert property (!(vbus_pulse && vbus_discharge))
      else $error("pulse and discharge overlap");
   chk_dis_after_pulse: assert property ($rose(vbus_discharge) |-> $past(vbus_pulse))
      else $error("discharge without pulse");
   chk_pulse_start: assert property ($rose(vbus_pulse) |-> $past(reg_wr)
      && $past(reg_addr) == 12'h830 && $past(reg_wdata[0])) else $error("pulse without start");
   chk_out_quiet: assert property ((out_ep_flags == 0) [*3] |=> !global_out_endpoint_flag)
      else $error("global out flag without events");
   chk_in_quiet: assert property ((in_ep_event == 0) [*3] |=> !global_in_endpoint_flag)
      else $error("global in flag without events");
endmodule // ueirq_monitor

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   // sim unit keeps srp phases short
   localparam UNIT = 4;
   reg         mclk;
   reg         resetn;
   reg  [11:0] reg_addr;
   reg  [31:0] reg_wdata;
   reg         reg_wr;
   reg         reg_rd;
   wire [31:0] reg_rdata;
   reg  [27:0] out_ep_flags;
   reg  [3:0]  in_ep_event;
   wire        vbus_pulse;
   wire        vbus_discharge;
   wire        gout;
   wire        gin;
   wire        irq;
   integer     failures;
   integer     check_count;
   integer     b;
   integer     n;
   ueirq_top #(.EP_COUNT(4), .UNIT_CYCLES(UNIT)) dut (.mclk(mclk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .out_ep_flags(out_ep_flags), .in_ep_event(in_ep_event),
      .vbus_pulse(vbus_pulse), .vbus_discharge(vbus_discharge),
      .global_out_endpoint_flag(gout), .global_in_endpoint_flag(gin), .irq(irq));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d mismatches %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task wr(input [11:0] a, input [31:0] v);
      begin
         @(posedge mclk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= v;
         @(posedge mclk);
         reg_wr <= 1'b0;
      end
   endtask
   // read data stands one cycle only, so sample just after the taking edge
   task rd(input [11:0] a, input [31:0] exp);
      begin
         @(posedge mclk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge mclk);
         reg_rd <= 1'b0;
         #1 chk(reg_rdata, exp);
      end
   endtask
   task ev(input [27:0] f, input [3:0] i);
      begin
         @(posedge mclk);
         out_ep_flags <= f;
         in_ep_event <= i;
         repeat (4) @(posedge mclk);
      end
   endtask
   task t_regs;
      begin
         rd(12'h814, 32'h0); rd(12'h818, 32'h0); rd(12'h81c, 32'h0);
         rd(12'h828, 32'h17d7);
         rd(12'h82c, 32'h5b8);
         wr(12'h814, 32'hffffffff); rd(12'h814, 32'h5b);
         wr(12'h81c, 32'hffffffff); rd(12'h81c, 32'h000f000f);
         wr(12'h828, 32'hffffffff); rd(12'h828, 32'hffff);
         wr(12'h818, 32'hffffffff); rd(12'h818, 32'h0); rd(12'h900, 32'h0);
      end
   endtask
   task t_gate;
      begin
         for (b = 0; b < 7; b = b + 1) begin
            wr(12'h814, 32'h1 << b);
            ev({7'h0, 7'h7f ^ (7'h1 << b), 7'h1 << b, 7'h1 << b}, 4'h0);
            n = (b == 2 || b == 5) ? 0 : (b == 3 || b == 6) ? 32'h10000 : 32'h30000;
            rd(12'h818, n);
            chk(gout, n != 0);
            ev(28'h0, 4'h0);
            rd(12'h818, 32'h0);
         end
      end
   endtask
   task t_mask;
      begin
         wr(12'h814, 32'h1);
         wr(12'h81c, 32'h00020004);
         ev(28'h1, 4'hb);
         rd(12'h818, 32'h0001000b);
         chk({gout, gin}, 2'h0);
         ev(28'h80, 4'h4);
         rd(12'h818, 32'h00020004);
         chk({gout, gin}, 2'h3);
         // overrun left from the gate sweep, both global flags rose here
         rd(12'h834, 32'he);
      end
   endtask
   task t_irq;
      begin
         ev(28'h0, 4'h0);
         wr(12'h838, 32'hf);
         rd(12'h834, 32'h0);
         wr(12'h83c, 32'h2);
         ev(28'h80, 4'h0);
         chk(irq, 1'b1);
         rd(12'h834, 32'h2);
         wr(12'h83c, 32'h0);
         repeat (2) @(posedge mclk);
         chk(irq, 1'b0);
         wr(12'h83c, 32'h2);
         ev(28'h0, 4'h0);
         chk(irq, 1'b1);
         wr(12'h838, 32'h2);
         repeat (2) @(posedge mclk);
         chk(irq, 1'b0);
         rd(12'h834, 32'h0);
      end
   endtask
   task t_srp;
      begin
         wr(12'h82c, 32'h2);
         wr(12'h828, 32'h3);
         wr(12'h830, 32'h1);
         n = 0;
         #1 while (vbus_pulse === 1'b1 && n < 100) begin
            @(posedge mclk);
            #1 n = n + 1;
         end
         chk(n, 2 * UNIT);
         n = 0;
         while (vbus_discharge === 1'b1 && n < 100) begin
            @(posedge mclk);
            #1 n = n + 1;
         end
         chk(n, 3 * UNIT);
         rd(12'h834, 32'h1);
         // zero discharge: pulse only, done still reported
         wr(12'h838, 32'h1);
         wr(12'h828, 32'h0);
         wr(12'h830, 32'h1);
         rd(12'h830, 32'h1);
         repeat (2 * UNIT) @(posedge mclk);
         #1 chk({vbus_discharge, vbus_pulse}, 32'h0);
         rd(12'h834, 32'h1);
      end
   endtask
   initial begin
      failures = 0;
      check_count = 0;
      resetn = 1'b0;
      reg_addr = 12'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      out_ep_flags = 28'h0;
      in_ep_event = 4'h0;
      repeat (4) @(posedge mclk);
      resetn <= 1'b1;
      t_regs;
      t_gate;
      t_mask;
      t_irq;
      t_srp;
      stop_test;
   end
   initial begin
      #100000;
      failures = failures + 1;
      stop_test;
   end
endmodule // testbench
bind ueirq_top ueirq_monitor #(.EP_COUNT(EP_COUNT)) mon (.mclk(mclk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .out_ep_flags(out_ep_flags), .in_ep_event(in_ep_event),
   .vbus_pulse(vbus_pulse), .vbus_discharge(vbus_discharge), .irq(irq),
   .global_out_endpoint_flag(global_out_endpoint_flag),
   .global_in_endpoint_flag(global_in_endpoint_flag));
